/* src/eas_seq.sv */
// event/action sequencer with comparators and logic rules
// assumes one 250 MHz clock, inputs synchronous to it, and a software register port
//
// Design decisions made here: the plain strobed port and the register offsets.
`timescale 1ns/100ps
`include "eas_regs.svh"

module eas_seq
    import eas_pkg::*;
#(
    parameter int NPAIR = 20,
    parameter int NCMP = 4,
    parameter int NLR = 4,
    parameter int NVAR = 4,
    parameter int SCAN_CYC = `EAS_SCAN_CYC
)(
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // register port
    input wire eas_req_t req,
    output logic [31:0] rdata,
    // condition sources
    input wire logic [3:0] timer_in,
    input wire logic [7:0] din,
    input wire logic [11:0] status_in,
    input wire logic [NVAR-1:0][15:0] var_in,
    // results
    output eas_act_t act,
    output logic [NCMP-1:0] cmp_out,
    output logic [NLR-1:0] lr_out,
    output logic running
);

    // ----------------------------------------------------------------
    // elaboration checks
    // ----------------------------------------------------------------
    // indices are five bits and selectors two bits wide
    if (NPAIR < 1 || NPAIR > 20 || NCMP < 1 || NCMP > 4 || NLR < 1 || NLR > 4 ||
        NVAR < 1 || NVAR > 4 || SCAN_CYC < 2 || SCAN_CYC > 16777215)
    begin : g_bad_param
        $error("eas_seq: parameter out of range");
    end

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        eas_state_t st;
        logic [31:0] ctrl;
        logic [NPAIR-1:0][7:0] evt_cfg;
        logic [NPAIR-1:0][7:0] act_cfg;
        logic [NCMP-1:0][31:0] cmp_cfg;
        logic [NLR-1:0][31:0] lr_cfg;
        logic [23:0] scan_cnt;
        logic tick;
        logic [4:0] idx;
        logic evt_hit;
        eas_act_t act;
        logic [NCMP-1:0] cmp_res;
        logic [NLR-1:0] lr_res;
        logic [31:0] rdata;
    } eas_st_t;

    eas_st_t s_q;
    eas_st_t s_d;

    // ----------------------------------------------------------------
    // comparators and logic rules
    // ----------------------------------------------------------------
    logic [NCMP-1:0] cmp_now;
    logic [NLR-1:0] lr_now;
    logic [31:0] pool;

    // boolean pool for rule inputs; event result bits come from flops so no loop forms
    // unused comparator slots are zero-extended rather than replicated
    assign pool = {1'b0, 1'b1, s_q.act.valid, s_q.evt_hit, status_in, din,
                   4'(cmp_now), timer_in};

    genvar gc;
    generate
        for (gc = 0; gc < NCMP; gc++)
        begin : g_cmp
            logic [15:0] v;
            logic [15:0] pre;
            assign v = var_in[s_q.cmp_cfg[gc][1:0] % NVAR];
            assign pre = s_q.cmp_cfg[gc][`EAS_CMP_PRE_HI:`EAS_CMP_PRE_LO];
            // unsigned relation against the stored preset
            always_comb
            begin
                case (eas_cmp_op_t'(s_q.cmp_cfg[gc][3:2]))
                    EAS_CMP_GT: cmp_now[gc] = v > pre;
                    EAS_CMP_LT: cmp_now[gc] = v < pre;
                    EAS_CMP_EQ: cmp_now[gc] = v == pre;
                    default: cmp_now[gc] = v != pre;
                endcase
            end
        end
        for (gc = 0; gc < NLR; gc++)
        begin : g_lr
            logic [31:0] c;
            logic a0;
            logic a1;
            logic a2;
            logic ab;
            assign c = s_q.lr_cfg[gc];
            // each input may be inverted, which gives NOT
            assign a0 = pool[c[4:0]] ^ c[5];
            assign a1 = pool[c[10:6]] ^ c[11];
            assign a2 = pool[c[16:12]] ^ c[17];
            always_comb
            begin
                case (eas_lop_t'(c[19:18]))
                    EAS_LOP_AND: ab = a0 & a1;
                    EAS_LOP_OR: ab = a0 | a1;
                    default: ab = a0;
                endcase
                case (eas_lop_t'(c[21:20]))
                    EAS_LOP_AND: lr_now[gc] = ab & a2;
                    EAS_LOP_OR: lr_now[gc] = ab | a2;
                    default: lr_now[gc] = ab;
                endcase
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // current event and programmed length
    // ----------------------------------------------------------------
    logic [4:0] cnt_raw;
    logic [4:0] last;
    logic [7:0] ecfg;
    logic [4:0] esel;
    logic evt_true;

    assign cnt_raw = s_q.ctrl[`EAS_CTRL_CNT_HI:`EAS_CTRL_CNT_LO];
    // zero reads as one pair, above the array as all pairs
    assign last = (cnt_raw == 5'h00) ? 5'h00 :
                  (cnt_raw > 5'(NPAIR)) ? 5'(NPAIR - 1) : cnt_raw - 5'h01;
    assign ecfg = s_q.evt_cfg[s_q.idx];
    assign esel = ecfg[`EAS_EVT_SEL_HI:`EAS_EVT_SEL_LO];

    // only the event at the current index is ever looked at
    always_comb
    begin
        case (eas_src_t'(ecfg[`EAS_EVT_KIND_HI:`EAS_EVT_KIND_LO]))
            EAS_SRC_STATUS: evt_true = pool[esel];
            EAS_SRC_LOGIC: evt_true = lr_now[esel % NLR];
            EAS_SRC_CMP: evt_true = cmp_now[esel % NCMP];
            default: evt_true = 1'b0;
        endcase
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    logic [3:0] region;
    logic [5:0] entry;
    logic fire;

    assign region = req.addr[11:8];
    assign entry = req.addr[7:2];
    assign fire = s_q.st == EAS_ST_RUN && s_q.tick && evt_true;

    always_comb
    begin
        s_d = s_q;
        s_d.act.valid = 1'b0;
        s_d.cmp_res = cmp_now;
        s_d.lr_res = lr_now;

        // free-running scan tick, one cycle wide
        if (s_q.scan_cnt == 24'h000000)
        begin
            s_d.scan_cnt = 24'(SCAN_CYC - 1);
            s_d.tick = 1'b1;
        end
        else
        begin
            s_d.scan_cnt = s_q.scan_cnt - 24'h000001;
            s_d.tick = 1'b0;
        end

        // register writes
        if (req.wr)
        begin
            if (req.addr == `EAS_CTRL_OFS)
                s_d.ctrl = req.wdata;
            else if (region == `EAS_REG_EVT && entry < 6'(NPAIR))
                s_d.evt_cfg[entry] = req.wdata[7:0];
            else if (region == `EAS_REG_ACT && entry < 6'(NPAIR))
                s_d.act_cfg[entry] = req.wdata[7:0];
            else if (region == `EAS_REG_CMP && entry < 6'(NCMP))
                s_d.cmp_cfg[entry] = req.wdata;
            else if (region == `EAS_REG_LR && entry < 6'(NLR))
                s_d.lr_cfg[entry] = req.wdata;
        end

        // register reads; unmapped addresses answer zero
        s_d.rdata = 32'h00000000;
        if (req.rd)
        begin
            if (req.addr == `EAS_CTRL_OFS)
                s_d.rdata = s_q.ctrl;
            else if (req.addr == `EAS_STAT_OFS)
                s_d.rdata = {8'h00, s_q.act.code, 3'h0, s_q.idx,
                             6'h00, s_q.evt_hit, s_q.st == EAS_ST_RUN};
            else if (region == `EAS_REG_EVT && entry < 6'(NPAIR))
                s_d.rdata = {24'h000000, s_q.evt_cfg[entry]};
            else if (region == `EAS_REG_ACT && entry < 6'(NPAIR))
                s_d.rdata = {24'h000000, s_q.act_cfg[entry]};
            else if (region == `EAS_REG_CMP && entry < 6'(NCMP))
                s_d.rdata = s_q.cmp_cfg[entry];
            else if (region == `EAS_REG_LR && entry < 6'(NLR))
                s_d.rdata = s_q.lr_cfg[entry];
        end

        // sequencer
        case (s_q.st)
            EAS_ST_STOP:
            begin
                s_d.idx = 5'h00;
                s_d.evt_hit = 1'b0;
                if (s_q.ctrl[`EAS_CTRL_RUN])
                    s_d.st = EAS_ST_RUN;
            end
            EAS_ST_RUN:
            begin
                if (!s_q.ctrl[`EAS_CTRL_RUN])
                begin
                    s_d.st = EAS_ST_STOP;
                    s_d.idx = 5'h00;
                end
                else if (s_q.tick)
                begin
                    s_d.evt_hit = evt_true;
                    // a false event leaves index and action alone
                    if (fire)
                    begin
                        s_d.act.valid = 1'b1;
                        s_d.act.index = s_q.idx;
                        s_d.act.code = s_q.act_cfg[s_q.idx];
                        s_d.idx = (s_q.idx >= last) ? 5'h00 : s_q.idx + 5'h01;
                    end
                end
                else if (s_q.idx > last)
                    s_d.idx = 5'h00;
            end
            default:
                s_d.st = EAS_ST_STOP;
        endcase
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            s_q <= '0;
            s_q.st <= EAS_ST_STOP;
            s_q.ctrl <= `EAS_CTRL_RST;
            s_q.scan_cnt <= 24'(SCAN_CYC - 1);
        end
        else
            s_q <= s_d;
    end

    // outputs straight from the state flops
    assign rdata = s_q.rdata;
    assign act = s_q.act;
    assign cmp_out = s_q.cmp_res;
    assign lr_out = s_q.lr_res;
    assign running = s_q.st == EAS_ST_RUN;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    sequence s_fire;
        s_q.st == EAS_ST_RUN && s_q.ctrl[`EAS_CTRL_RUN] && s_q.tick && evt_true;
    endsequence

    sequence s_idle_eval;
        s_q.st == EAS_ST_RUN && s_q.ctrl[`EAS_CTRL_RUN] && s_q.tick && !evt_true;
    endsequence

    chk_act_needs_true: assert property (
        s_q.act.valid |-> $past(s_q.tick) && $past(evt_true) &&
        $past(s_q.st) == EAS_ST_RUN)
        else $error("action fired without a true event");

    chk_act_pair_match: assert property (
        s_fire |=> s_q.act.valid && s_q.act.index == $past(s_q.idx) &&
        s_q.act.code == $past(s_q.act_cfg[s_q.idx]))
        else $error("action does not match event index");

    chk_idx_next: assert property (
        s_fire ##0 (s_q.idx < last) |=> s_q.idx == $past(s_q.idx) + 5'h01)
        else $error("index did not advance after action");

    chk_one_step: assert property (
        s_q.idx != $past(s_q.idx) |-> s_q.idx == 5'h00 ||
        s_q.idx == $past(s_q.idx) + 5'h01)
        else $error("index moved by more than one");

    chk_false_hold: assert property (
        s_idle_eval |=> !s_q.act.valid && s_q.idx == $past(s_q.idx))
        else $error("false event changed state");

    chk_start_zero: assert property (
        $rose(running) |-> s_q.idx == 5'h00 ##1
        (s_q.idx == 5'h00 || (s_q.act.valid && s_q.act.index == 5'h00)))
        else $error("start not at event zero");

    chk_idx_bound: assert property (
        s_q.tick && running |-> s_q.idx <= last)
        else $error("index beyond programmed pairs");

    chk_wrap_zero: assert property (
        s_fire ##0 (s_q.idx >= last) |=> s_q.idx == 5'h00)
        else $error("no wrap after last pair");

    chk_cmp_result: assert property (
        ##1 cmp_out == $past(cmp_now))
        else $error("comparator result not registered");

    chk_tick_single: assert property (
        s_q.tick |=> !s_q.tick [*2])
        else $error("scan tick longer than one cycle");

    chk_stop_clears: assert property (
        !running |-> s_q.idx == 5'h00)
        else $error("index not zero while stopped");

endmodule

/* src/eas_regs.svh */
// register offsets, field positions, reset values and timing counts
// assumes byte addresses on a 12-bit register port, one 32-bit word per register
`ifndef EAS_REGS_SVH
`define EAS_REGS_SVH

// ----------------------------------------------------------------
// register map (region in addr[11:8], entry in addr[7:2])
// ----------------------------------------------------------------
`define EAS_ADDR_W 12
`define EAS_CTRL_OFS 12'h000
`define EAS_STAT_OFS 12'h004
`define EAS_REG_EVT 4'h1
`define EAS_REG_ACT 4'h2
`define EAS_REG_CMP 4'h3
`define EAS_REG_LR 4'h4

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define EAS_CTRL_RUN 0
`define EAS_CTRL_CNT_LO 8
`define EAS_CTRL_CNT_HI 12
`define EAS_CTRL_RST 32'h0000_0100
`define EAS_EVT_KIND_LO 0
`define EAS_EVT_KIND_HI 1
`define EAS_EVT_SEL_LO 2
`define EAS_EVT_SEL_HI 6
`define EAS_CMP_PRE_LO 16
`define EAS_CMP_PRE_HI 31

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define EAS_CLK_NS 4
`define EAS_SCAN_NS 1000000
`define EAS_SCAN_CYC (`EAS_SCAN_NS / `EAS_CLK_NS)

`endif

/* src/eas_pkg.sv */
// types shared by the event/action sequencer
// assumes the register header is included by the design file
package eas_pkg;

    // one-hot sequencer states
    typedef enum logic [1:0] {
        EAS_ST_STOP = 2'b01,
        EAS_ST_RUN = 2'b10
    } eas_state_t;

    // where an event condition comes from
    typedef enum logic [1:0] {
        EAS_SRC_STATUS = 2'h0,
        EAS_SRC_LOGIC = 2'h1,
        EAS_SRC_CMP = 2'h2,
        EAS_SRC_NEVER = 2'h3
    } eas_src_t;

    // comparator relation of variable to preset
    typedef enum logic [1:0] {
        EAS_CMP_GT = 2'h0,
        EAS_CMP_LT = 2'h1,
        EAS_CMP_EQ = 2'h2,
        EAS_CMP_NE = 2'h3
    } eas_cmp_op_t;

    // logic rule operator; pass keeps the left operand alone
    typedef enum logic [1:0] {
        EAS_LOP_AND = 2'h0,
        EAS_LOP_OR = 2'h1,
        EAS_LOP_PASS = 2'h2,
        EAS_LOP_PASS2 = 2'h3
    } eas_lop_t;

    // register port request
    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } eas_req_t;

    // fired action
    typedef struct packed {
        logic valid;
        logic [4:0] index;
        logic [7:0] code;
    } eas_act_t;

endpackage

/* dv/eas_seq_tb.sv */
// self-checking bench for the event/action sequencer
// assumes eas_pkg and the register header are on the compile path
`timescale 1ns/100ps
`include "eas_regs.svh"

module eas_seq_tb;
    import eas_pkg::*;

    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    localparam int SCAN = 16; // short scan interval keeps the run brief
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    eas_req_t req = '0;
    logic [31:0] rdata;
    logic [3:0] timer_in = '0;
    logic [7:0] din = '0;
    logic [11:0] status_in = '0;
    logic [3:0][15:0] var_in = '0;
    eas_act_t act;
    logic [3:0] cmp_out;
    logic [3:0] lr_out;
    logic running;
    int err_total = 0;
    int comparisons = 0;
    int n;

    always #2 mclk = ~mclk;

    eas_seq #(.SCAN_CYC(SCAN)) DUT (.mclk(mclk), .resetn(resetn), .req(req), .rdata(rdata),
        .timer_in(timer_in), .din(din), .status_in(status_in), .var_in(var_in),
        .act(act), .cmp_out(cmp_out), .lr_out(lr_out), .running(running));

    // ------------------------------------------------------------
    // compare, bus and wait helpers
    // ------------------------------------------------------------
    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one-cycle strobes; the extra edge keeps two calls from colliding
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        req <= '{a, d, 1'b1, 1'b0};
        @(posedge mclk);
        req.wr <= 1'b0;
    endtask

    // read data only stand in the cycle after the strobe
    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] m);
        @(posedge mclk);
        req <= '{a, 32'h0000_0000, 1'b0, 1'b1};
        @(posedge mclk);
        req.rd <= 1'b0;
        @(negedge mclk);
        cmp_word(rdata & m, exp);
    endtask

    function automatic logic [11:0] ent(input logic [3:0] reg_grp, input int i);
        return {reg_grp, i[5:0], 2'b00};
    endfunction

    // bounded wait for a fired action, then check it is a single pulse
    task automatic wait_fire(input logic [4:0] idx, input logic [7:0] code, output int cnt);
        cnt = 0;
        do
        begin
            @(negedge mclk);
            cnt++;
        end
        while (act.valid !== 1'b1 && cnt < 4 * SCAN);
        cmp_word({31'h0, act.valid}, 32'h1);
        cmp_word({19'h0, act.index, act.code}, {19'h0, idx, code});
        @(negedge mclk);
        cmp_word({31'h0, act.valid}, 32'h0);
    endtask

    // no action may fire over the given span
    task automatic quiet(input int cyc);
        int fired;
        fired = 0;
        repeat (cyc)
        begin
            @(negedge mclk);
            if (act.valid !== 1'b0)
                fired++;
        end
        cmp_word(fired, 0);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        rd(`EAS_CTRL_OFS, `EAS_CTRL_RST, 32'hFFFF_FFFF);
        rd(`EAS_STAT_OFS, 32'h0000_0000, 32'hFFFF_FFFF);
        wr(`EAS_STAT_OFS, 32'hFFFF_FFFF);
        rd(`EAS_STAT_OFS, 32'h0000_0000, 32'hFFFF_FFFF);
        wr(ent(`EAS_REG_EVT, 20), 32'h0000_0001);
        rd(ent(`EAS_REG_EVT, 20), 32'h0000_0000, 32'hFFFF_FFFF);
        rd(12'hFFC, 32'h0000_0000, 32'hFFFF_FFFF);
    endtask

    // four status-driven pairs: hold at zero, step, wrap, stall mid-run
    task automatic t_order;
        for (int i = 0; i < 4; i++)
        begin
            wr(ent(`EAS_REG_EVT, i), (16 + i) << 2);
            wr(ent(`EAS_REG_ACT, i), 32'h0000_00A0 + i);
        end
        wr(`EAS_CTRL_OFS, 32'h0000_0401);
        rd(`EAS_STAT_OFS, 32'h0000_0001, 32'h00FF_1F03);
        cmp_word({31'h0, running}, 32'h1);
        quiet(3 * SCAN);
        @(posedge mclk);
        status_in <= 12'h001;
        wait_fire(5'h00, 8'hA0, n);
        @(posedge mclk);
        status_in <= 12'h00F;
        for (int i = 1; i < 5; i++)
        begin
            wait_fire(5'(i % 4), 8'hA0 + 8'(i % 4), n);
            cmp_word(n, SCAN - 1);
        end
        @(posedge mclk);
        status_in <= 12'h00D;
        quiet(3 * SCAN);
        rd(`EAS_STAT_OFS, 32'h00A0_0101, 32'h00FF_1F03);
        wr(`EAS_CTRL_OFS, 32'h0000_0400);
        rd(`EAS_STAT_OFS, 32'h00A0_0000, 32'h00FF_1F03);
        cmp_word({31'h0, running}, 32'h0);
    endtask

    // pair count bounds: zero reads as one, above twenty clamps to twenty
    task automatic t_count;
        for (int i = 0; i < 20; i++)
        begin
            wr(ent(`EAS_REG_EVT, i), 32'h0000_0078);
            wr(ent(`EAS_REG_ACT, i), i);
        end
        wr(`EAS_CTRL_OFS, 32'h0000_0001);
        wait_fire(5'h00, 8'h00, n);
        wait_fire(5'h00, 8'h00, n);
        wr(`EAS_CTRL_OFS, 32'h0000_0000);
        wr(`EAS_CTRL_OFS, 32'h0000_1501);
        for (int i = 0; i < 21; i++)
            wait_fire(5'(i % 20), 8'(i % 20), n);
        wr(`EAS_CTRL_OFS, 32'h0000_0000);
    endtask

    // every relation around a preset, then a comparator as the event
    task automatic t_cmp;
        logic [15:0] vals[3] = '{16'h0FFF, 16'h1000, 16'h1001};
        logic e;
        for (int op = 0; op < 4; op++)
        begin
            wr(ent(`EAS_REG_CMP, 0), 32'h1000_0001 | (op << 2));
            foreach (vals[k])
            begin
                @(posedge mclk);
                var_in[1] <= vals[k];
                @(posedge mclk);
                @(negedge mclk);
                e = (op == 0) ? vals[k] > 16'h1000 : (op == 1) ? vals[k] < 16'h1000 :
                    (op == 2) ? vals[k] == 16'h1000 : vals[k] != 16'h1000;
                cmp_word({31'h0, cmp_out[0]}, {31'h0, e});
            end
        end
        wr(ent(`EAS_REG_CMP, 0), 32'h1000_0001);
        wr(ent(`EAS_REG_EVT, 0), 32'h0000_0002);
        wr(ent(`EAS_REG_ACT, 0), 32'h0000_005A);
        wr(`EAS_CTRL_OFS, 32'h0000_0101);
        wait_fire(5'h00, 8'h5A, n);
        @(posedge mclk);
        var_in[1] <= 16'h0FFF;
        quiet(3 * SCAN);
        wr(`EAS_CTRL_OFS, 32'h0000_0100);
    endtask

    // timer and input combined by and/or with inversion, then as the event
    task automatic t_lr;
        logic e;
        for (int op = 0; op < 2; op++)
            for (int inv = 0; inv < 2; inv++)
            begin
                wr(ent(`EAS_REG_LR, 0), 32'h0003_F200 | (inv << 11) | (op << 18));
                for (int c = 0; c < 4; c++)
                begin
                    @(posedge mclk);
                    timer_in[0] <= c[0];
                    din[0] <= c[1];
                    @(posedge mclk);
                    @(negedge mclk);
                    e = op ? (c[0] | (c[1] ^ inv[0])) : (c[0] & (c[1] ^ inv[0]));
                    cmp_word({31'h0, lr_out[0]}, {31'h0, e});
                end
            end
        // left operand alone but inverted, or-ed with a plain input
        wr(ent(`EAS_REG_LR, 1), 32'h0018_8020);
        for (int c = 0; c < 4; c++)
        begin
            @(posedge mclk);
            timer_in[0] <= c[0];
            din[0] <= c[1];
            @(posedge mclk);
            @(negedge mclk);
            e = !c[0] | c[1];
            cmp_word({31'h0, lr_out[1]}, {31'h0, e});
        end
        wr(ent(`EAS_REG_EVT, 0), 32'h0000_0001);
        wr(`EAS_CTRL_OFS, 32'h0000_0101);
        wait_fire(5'h00, 8'h5A, n);
        // an event of the never kind must stall the pair
        wr(ent(`EAS_REG_EVT, 0), 32'h0000_0003);
        quiet(3 * SCAN);
        wr(`EAS_CTRL_OFS, 32'h0000_0100);
    endtask

    // ------------------------------------------------------------
    // verdict, watchdog and main sequence
    // ------------------------------------------------------------
    task automatic end_of_test;
        if (err_total == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // generous span for the whole sequence at this scan interval
    initial
    begin
        repeat (20000) @(posedge mclk);
        err_total++;
        end_of_test();
    end

    initial
    begin
        repeat (10) @(posedge mclk);
        resetn <= 1'b1;
        t_reset();
        t_order();
        t_count();
        t_cmp();
        t_lr();
        end_of_test();
    end
endmodule
